// [rtl/flash_power_state_control.sv]
`timescale 1ns/1ps
module flash_power_state_control
  import flash_pwr_pkg::*;
#(
  parameter logic [7:0] P_WAKE_CODE      = flash_pwr_pkg::WAKE_CODE,
  parameter int         P_WAKE_RECOVERY  = flash_pwr_pkg::WAKE_RECOVERY_CYC,
  parameter int         P_PD_ENTRY       = flash_pwr_pkg::PD_ENTRY_CYC,
  parameter int         P_WRITE_INHIBIT  = flash_pwr_pkg::WRITE_INHIBIT_MIN_CYC
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_b,
  flash_link_if.dev                      link,
  input  wire logic                      i_cycle_start,
  input  wire logic                      i_cycle_done,
  output flash_pwr_pkg::pwr_state_t      o_power_state,
  output logic                           o_write_inhibit,
  output logic [7:0]                     o_status,
  output logic [7:0]                     o_array_fill,
  output logic                           o_cmd_valid,
  output logic [7:0]                     o_cmd_code
);
  import flash_pwr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers: cs_b, sclk, sdi, reset_b
  // ----------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       cs_b_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       link_hold;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      // idle levels: a high clock here would fake an edge after reset
      meta_q <= 4'h9;
      sync_q <= 4'h9;
    end else begin
      meta_q <= {link.reset_b, link.sdi, link.sclk, link.cs_b};
      sync_q <= meta_q;
    end
  end

  assign cs_b_s    = sync_q[0];
  assign sclk_s    = sync_q[1];
  assign sdi_s     = sync_q[2];
  assign link_hold = ~sync_q[3];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pwr_state_t  state_q,   state_d;
  logic        cs_prev_q, cs_prev_d;
  logic        sclk_prev_q, sclk_prev_d;
  logic [7:0]  shift_q,   shift_d;
  logic [3:0]  bits_q,    bits_d;
  logic [31:0] timer_q,   timer_d;
  logic [31:0] inhibit_q, inhibit_d;
  logic        wip_q,     wip_d;
  logic        wel_q,     wel_d;
  logic        valid_q,   valid_d;
  logic [7:0]  code_q,    code_d;
  logic [7:0]  fill_q,    fill_d;

  function automatic logic is_write_class(input logic [7:0] code);
    return (code == WRITE_ENABLE_CODE) || (code == PAGE_REWRITE_CODE) ||
           (code == PAGE_PROGRAM_CODE) || (code == PAGE_ERASE_CODE) ||
           (code == SECTOR_ERASE_CODE);
  endfunction

  logic       sclk_rise;
  logic       cs_rise;
  logic       byte_done;
  logic [7:0] code_now;
  logic       exact_byte;
  logic       inhibit;

  always_comb begin
    sclk_rise   = sclk_s & ~sclk_prev_q;
    cs_rise     = cs_b_s & ~cs_prev_q;
    code_now    = {shift_q[6:0], sdi_s};
    byte_done   = ~cs_b_s & sclk_rise & (bits_q == 4'h7);
    // a single-byte instruction counts only with exactly eight clocks
    exact_byte  = cs_rise & (bits_q == 4'h8);
    inhibit     = (inhibit_q != 32'h0);

    cs_prev_d   = cs_b_s;
    sclk_prev_d = sclk_s;
    shift_d     = shift_q;
    bits_d      = bits_q;
    state_d     = state_q;
    timer_d     = timer_q;
    inhibit_d   = inhibit ? inhibit_q - 32'h1 : inhibit_q;
    wip_d       = wip_q;
    wel_d       = wel_q;
    valid_d     = 1'b0;
    code_d      = code_q;
    fill_d      = fill_q;

    if (cs_b_s) begin
      bits_d = 4'h0;
    end else if (sclk_rise) begin
      shift_d = code_now;
      if (bits_q != 4'hF) begin
        bits_d = bits_q + 4'h1;
      end
    end

    // first byte of every instruction goes out only from standby;
    // write class is dropped while inhibited or busy
    if (byte_done && state_q == PWR_STANDBY) begin
      if (!(is_write_class(code_now) && (inhibit || wip_q))) begin
        valid_d = 1'b1;
        code_d  = code_now;
      end
    end

    // a cycle start consumes the latch; a write enable decoded in the same cycle wins
    if (i_cycle_start) begin
      wel_d = 1'b0;
    end

    unique case (state_q)
      PWR_STANDBY: begin
        if (exact_byte && !wip_q) begin
          if (shift_q == PD_CODE) begin
            state_d = PWR_PD_ENTRY;
            timer_d = 32'(P_PD_ENTRY);
          end else if (shift_q == WRITE_ENABLE_CODE && !inhibit) begin
            wel_d = 1'b1;
          end
        end
      end
      PWR_PD_ENTRY: begin
        if (timer_q <= 32'h1) begin
          state_d = PWR_DEEP_PD;
        end else begin
          timer_d = timer_q - 32'h1;
        end
      end
      PWR_DEEP_PD: begin
        // only the wake code is looked at here; a busy cycle rejects it
        if (exact_byte && shift_q == P_WAKE_CODE && !wip_q) begin
          state_d = PWR_WAKE;
          timer_d = 32'(P_WAKE_RECOVERY);
        end
      end
      PWR_WAKE: begin
        if (timer_q <= 32'h1) begin
          state_d = PWR_STANDBY;
        end else begin
          timer_d = timer_q - 32'h1;
        end
      end
    endcase

    // busy flag: start wins over done in the same cycle
    if (i_cycle_done) begin
      wip_d = 1'b0;
    end
    if (i_cycle_start) begin
      wip_d = 1'b1;
    end

    // reset pin from the host acts like the power-on reset, except that shift_q and code_q keep their values
    if (link_hold) begin
      state_d   = PWR_STANDBY;
      bits_d    = 4'h0;
      timer_d   = 32'h0;
      inhibit_d = 32'(P_WRITE_INHIBIT);
      wip_d     = 1'b0;
      wel_d     = 1'b0;
      valid_d   = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q     <= PWR_STANDBY;
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
      shift_q     <= 8'h00;
      bits_q      <= 4'h0;
      timer_q     <= 32'h0;
      inhibit_q   <= 32'(P_WRITE_INHIBIT);
      wip_q       <= 1'b0;
      wel_q       <= 1'b0;
      valid_q     <= 1'b0;
      code_q      <= 8'h00;
      fill_q      <= ERASED_BYTE;
    end else begin
      state_q     <= state_d;
      cs_prev_q   <= cs_prev_d;
      sclk_prev_q <= sclk_prev_d;
      shift_q     <= shift_d;
      bits_q      <= bits_d;
      timer_q     <= timer_d;
      inhibit_q   <= inhibit_d;
      wip_q       <= wip_d;
      wel_q       <= wel_d;
      valid_q     <= valid_d;
      code_q      <= code_d;
      fill_q      <= fill_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_status                 = STATUS_RESET;
    o_status[STATUS_WIP_BIT] = wip_q;
    o_status[STATUS_WEL_BIT] = wel_q;
  end

  assign o_power_state   = state_q;
  assign o_write_inhibit = (inhibit_q != 32'h0);
  assign o_array_fill    = fill_q;
  assign o_cmd_valid     = valid_q;
  assign o_cmd_code      = code_q;
endmodule

// [rtl/flash_pwr_pkg.sv]
package flash_pwr_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ              = 100;
  localparam int SELECT_DELAY_US      = 30;
  localparam int SELECT_DELAY_CYC     = SELECT_DELAY_US * CLK_MHZ;
  localparam int WRITE_INHIBIT_MIN_MS = 1;
  localparam int WRITE_INHIBIT_MAX_MS = 10;
  localparam int WRITE_INHIBIT_MIN_CYC = WRITE_INHIBIT_MIN_MS * 1000 * CLK_MHZ;
  localparam int WRITE_INHIBIT_MAX_CYC = WRITE_INHIBIT_MAX_MS * 1000 * CLK_MHZ;
  localparam int WAKE_RECOVERY_CYC    = 300;
  localparam int PD_ENTRY_CYC         = 300;
  localparam int SCLK_HALF_CYC        = 4;
  localparam int CS_GUARD_CYC         = 8;
  // ----------------------------------------------------------------
  // instruction codes and status layout
  // ----------------------------------------------------------------
  localparam int         INSTR_BITS        = 8;
  localparam logic [7:0] WAKE_CODE         = 8'hA1;
  localparam logic [7:0] PD_CODE           = 8'hA2;
  localparam logic [7:0] WRITE_ENABLE_CODE = 8'hA3;
  localparam logic [7:0] PAGE_REWRITE_CODE = 8'hA4;
  localparam logic [7:0] PAGE_PROGRAM_CODE = 8'hA5;
  localparam logic [7:0] PAGE_ERASE_CODE   = 8'hA6;
  localparam logic [7:0] SECTOR_ERASE_CODE = 8'hA7;
  localparam int         STATUS_WIP_BIT    = 0;
  localparam int         STATUS_WEL_BIT    = 1;
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam logic [7:0] ERASED_BYTE       = 8'hFF;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_STANDBY  = 2'h0,
    PWR_PD_ENTRY = 2'h1,
    PWR_DEEP_PD  = 2'h3,
    PWR_WAKE     = 2'h2
  } pwr_state_t;
  typedef enum logic [1:0] {
    HST_POWER_UP = 2'h0,
    HST_IDLE     = 2'h1,
    HST_SHIFT    = 2'h3,
    HST_GUARD    = 2'h2
  } host_state_t;
endpackage

// [rtl/flash_link_if.sv]
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_b;
  logic sclk;
  logic sdi;
  logic reset_b;
  modport host (output cs_b, output sclk, output sdi, output reset_b);
  modport dev  (input cs_b, input sclk, input sdi, input reset_b);
endinterface

// [rtl/flash_host_end.sv]
`timescale 1ns/1ps
module flash_host_end
  import flash_pwr_pkg::*;
#(
  parameter logic [7:0] P_WAKE_CODE     = flash_pwr_pkg::WAKE_CODE,
  parameter int         P_WAKE_RECOVERY = flash_pwr_pkg::WAKE_RECOVERY_CYC,
  parameter int         P_PD_ENTRY      = flash_pwr_pkg::PD_ENTRY_CYC,
  parameter int         P_SELECT_DELAY  = flash_pwr_pkg::SELECT_DELAY_CYC,
  parameter int         P_WRITE_INHIBIT = flash_pwr_pkg::WRITE_INHIBIT_MAX_CYC,
  parameter int         P_SCLK_HALF     = flash_pwr_pkg::SCLK_HALF_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  flash_link_if.host      link,
  input  wire logic       i_start,
  input  wire logic [7:0] i_instr,
  input  wire logic [3:0] i_extra_clocks,
  output logic            o_ready,
  output logic            o_write_allowed
);
  import flash_pwr_pkg::*;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  host_state_t state_q, state_d;
  logic [31:0] wait_q,  wait_d;
  logic [31:0] wr_q,    wr_d;
  logic [31:0] half_q,  half_d;
  logic [4:0]  left_q,  left_d;
  logic [7:0]  data_q,  data_d;
  logic [7:0]  instr_q, instr_d;
  logic        cs_b_q,  cs_b_d;
  logic        sclk_q,  sclk_d;
  logic        rst_b_q, rst_b_d;
  logic        is_write;

  always_comb begin
    is_write = (i_instr == WRITE_ENABLE_CODE) || (i_instr == PAGE_REWRITE_CODE) ||
               (i_instr == PAGE_PROGRAM_CODE) || (i_instr == PAGE_ERASE_CODE) ||
               (i_instr == SECTOR_ERASE_CODE);
    state_d = state_q;
    wait_d  = (wait_q != 32'h0) ? wait_q - 32'h1 : wait_q;
    wr_d    = (wr_q != 32'h0) ? wr_q - 32'h1 : wr_q;
    half_d  = half_q;
    left_d  = left_q;
    data_d  = data_q;
    instr_d = instr_q;
    cs_b_d  = cs_b_q;
    sclk_d  = sclk_q;
    rst_b_d = rst_b_q;

    unique case (state_q)
      HST_POWER_UP: begin
        // device stays deselected and reset through the supply ramp
        cs_b_d  = 1'b1;
        rst_b_d = 1'b0;
        if (wait_q == 32'h0) begin
          rst_b_d = 1'b1;
          state_d = HST_IDLE;
        end
      end
      HST_IDLE: begin
        // write-class requests before the inhibit delay are dropped
        if (i_start && !(is_write && wr_q != 32'h0)) begin
          state_d = HST_SHIFT;
          cs_b_d  = 1'b0;
          sclk_d  = 1'b0;
          data_d  = i_instr;
          instr_d = i_instr;
          left_d  = 5'(INSTR_BITS) + {1'b0, i_extra_clocks};
          half_d  = 32'(P_SCLK_HALF);
        end
      end
      HST_SHIFT: begin
        if (half_q > 32'h1) begin
          half_d = half_q - 32'h1;
        end else begin
          half_d = 32'(P_SCLK_HALF);
          if (!sclk_q) begin
            sclk_d = 1'b1;
          end else begin
            sclk_d = 1'b0;
            data_d = {data_q[6:0], 1'b0};
            left_d = left_q - 5'h1;
            if (left_q == 5'h1) begin
              cs_b_d  = 1'b1;
              state_d = HST_GUARD;
              // select stays high through recovery or entry delay
              if (instr_q == P_WAKE_CODE) begin
                wait_d = 32'(P_WAKE_RECOVERY);
              end else if (instr_q == PD_CODE) begin
                wait_d = 32'(P_PD_ENTRY);
              end else begin
                wait_d = 32'(CS_GUARD_CYC);
              end
            end
          end
        end
      end
      HST_GUARD: begin
        if (wait_q == 32'h0) begin
          state_d = HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= HST_POWER_UP;
      wait_q  <= 32'(P_SELECT_DELAY);
      wr_q    <= 32'(P_WRITE_INHIBIT > P_SELECT_DELAY ? P_WRITE_INHIBIT : P_SELECT_DELAY);
      half_q  <= 32'h0;
      left_q  <= 5'h0;
      data_q  <= 8'h00;
      instr_q <= 8'h00;
      cs_b_q  <= 1'b1;
      sclk_q  <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      wr_q    <= wr_d;
      half_q  <= half_d;
      left_q  <= left_d;
      data_q  <= data_d;
      instr_q <= instr_d;
      cs_b_q  <= cs_b_d;
      sclk_q  <= sclk_d;
      rst_b_q <= rst_b_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cs_b       = cs_b_q;
  assign link.sclk       = sclk_q;
  assign link.sdi        = data_q[7];
  assign link.reset_b    = rst_b_q;
  assign o_ready         = (state_q == HST_IDLE);
  assign o_write_allowed = (wr_q == 32'h0);
endmodule

// [dv/flash_link_sva.sv]
`timescale 1ns/1ps
module flash_link_sva
  import flash_pwr_pkg::*;
#(
  parameter int P_SELECT_DELAY  = SELECT_DELAY_CYC,
  parameter int P_WRITE_INHIBIT = WRITE_INHIBIT_MAX_CYC,
  parameter int P_WAKE_RECOVERY = WAKE_RECOVERY_CYC,
  parameter int P_PD_ENTRY      = PD_ENTRY_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic reset_b
);
  // ----------------------------------------------------------------
  // link trackers
  // ----------------------------------------------------------------
  logic [19:0] since_rst_q, since_rst_d;
  logic [15:0] hi_cnt_q, hi_cnt_d;
  logic [4:0]  bits_q, bits_d;
  logic [7:0]  code_q, code_d;
  logic        sclk_q, cs_q;
  logic        is_write;

  always_comb begin
    since_rst_d = (since_rst_q == 20'hFFFFF) ? since_rst_q : since_rst_q + 20'h00001;
    hi_cnt_d    = cs_b ? ((hi_cnt_q == 16'hFFFF) ? hi_cnt_q : hi_cnt_q + 16'h0001) : 16'h0000;
    bits_d      = bits_q;
    code_d      = code_q;
    // frame contents survive until the next select, so guards can judge them
    if (!cs_b && cs_q) begin
      bits_d = 5'h00;
      code_d = 8'h00;
    end else if (!cs_b && sclk && !sclk_q) begin
      bits_d = (bits_q == 5'h1F) ? bits_q : bits_q + 5'h01;
      if (bits_q < 5'h08) begin
        code_d = {code_q[6:0], sdi};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      since_rst_q <= 20'h00000;
      hi_cnt_q    <= 16'h0000;
      bits_q      <= 5'h00;
      code_q      <= 8'h00;
      sclk_q      <= 1'b0;
      cs_q        <= 1'b1;
    end else begin
      since_rst_q <= since_rst_d;
      hi_cnt_q    <= hi_cnt_d;
      bits_q      <= bits_d;
      code_q      <= code_d;
      sclk_q      <= sclk;
      cs_q        <= cs_b;
    end
  end

  assign is_write = code_q inside {WRITE_ENABLE_CODE, PAGE_REWRITE_CODE, PAGE_PROGRAM_CODE,
                                   PAGE_ERASE_CODE, SECTOR_ERASE_CODE};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  select_delay_a: assert property ($fell(cs_b) |-> since_rst_q >= P_SELECT_DELAY)
    else $error("select came before the supply to select delay");
  reset_desel_a: assert property (!reset_b |-> cs_b)
    else $error("device selected while its reset is low");
  idle_clock_a: assert property (cs_b |-> !sclk)
    else $error("serial clock high while deselected");
  first_edge_a: assert property ($fell(cs_b) |-> !sclk [*4] ##1 sclk)
    else $error("first clock rise not four cycles after select");
  clock_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("clock high phase not four cycles");
  data_stable_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("data changed while clock high");
  whole_byte_a: assert property ($rose(cs_b) |-> bits_q >= 5'h08)
    else $error("frame ended before eight clocks");
  wake_guard_a: assert property ($fell(cs_b) && bits_q == 5'h08
                                 && code_q == WAKE_CODE |-> hi_cnt_q >= P_WAKE_RECOVERY)
    else $error("select during wake recovery");
  pd_guard_a: assert property ($fell(cs_b) && bits_q == 5'h08
                               && code_q == PD_CODE |-> hi_cnt_q >= P_PD_ENTRY)
    else $error("select during power-down entry");
  write_wait_a: assert property ($rose(cs_b) && is_write
                                 |-> since_rst_q >= P_WRITE_INHIBIT)
    else $error("write-class code sent during write inhibit");
endmodule

// [dv/flash_power_state_control_bench.sv]
`timescale 1ns/1ps
module flash_power_state_control_bench;
  import flash_pwr_pkg::*;
  // shortened counts keep the run brief; host inhibit must not undercut the device's
  localparam int DEV_INHIBIT  = 200;
  localparam int HOST_INHIBIT = 300;
  localparam int SEL_DELAY    = 50;
  localparam int WAKE_REC     = 20;
  localparam int PD_ENTRY     = 20;
  localparam logic [7:0] READ_CODE = 8'h03;

  typedef struct packed {
    logic [7:0] instr;
    logic [3:0] extra;
    logic       exp_valid;
    logic [7:0] exp_code;
    logic [1:0] exp_state;
  } row_t;

  logic       i_clock = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_start = 1'b0;
  logic [7:0] i_instr = 8'h00;
  logic [3:0] i_extra_clocks = 4'h0;
  logic       i_cycle_start = 1'b0;
  logic       i_cycle_done = 1'b0;
  pwr_state_t o_power_state;
  logic       o_write_inhibit, o_cmd_valid, o_ready, o_write_allowed, seen_valid;
  logic [7:0] o_status, o_array_fill, o_cmd_code, seen_code;
  int         fails = 0;
  int         checked = 0;
  row_t       rows [7];

  always #5 i_clock = ~i_clock;

  flash_link_if flash_link_if_i ();
  flash_power_state_control #(.P_WAKE_RECOVERY(WAKE_REC), .P_PD_ENTRY(PD_ENTRY),
    .P_WRITE_INHIBIT(DEV_INHIBIT)) flash_power_state_control_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .link(flash_link_if_i), .i_cycle_start(i_cycle_start),
    .i_cycle_done(i_cycle_done), .o_power_state(o_power_state), .o_write_inhibit(o_write_inhibit),
    .o_status(o_status), .o_array_fill(o_array_fill), .o_cmd_valid(o_cmd_valid),
    .o_cmd_code(o_cmd_code));
  flash_host_end #(.P_WAKE_RECOVERY(WAKE_REC), .P_PD_ENTRY(PD_ENTRY), .P_SELECT_DELAY(SEL_DELAY),
    .P_WRITE_INHIBIT(HOST_INHIBIT)) flash_host_end_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .link(flash_link_if_i), .i_start(i_start),
    .i_instr(i_instr), .i_extra_clocks(i_extra_clocks), .o_ready(o_ready),
    .o_write_allowed(o_write_allowed));
  flash_link_sva #(.P_SELECT_DELAY(SEL_DELAY), .P_WRITE_INHIBIT(HOST_INHIBIT),
    .P_WAKE_RECOVERY(WAKE_REC), .P_PD_ENTRY(PD_ENTRY)) flash_link_sva_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .cs_b(flash_link_if_i.cs_b),
    .sclk(flash_link_if_i.sclk), .sdi(flash_link_if_i.sdi), .reset_b(flash_link_if_i.reset_b));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #1;
      if (o_cmd_valid === 1'b1) begin
        seen_valid = 1'b1;
        seen_code  = o_cmd_code;
      end
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      $display("CHECK FAILED host ready expected 1 seen %b", o_ready);
    end
  endtask

  // one frame, then a settling margin for the two-flop synchroniser
  task automatic send(input logic [7:0] instr, input logic [3:0] extra);
    wait_ready();
    seen_valid     = 1'b0;
    seen_code      = 8'h00;
    i_instr        = instr;
    i_extra_clocks = extra;
    i_start        = 1'b1;
    tick(1);
    i_start = 1'b0;
    wait_ready();
    tick(8);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{WRITE_ENABLE_CODE, 4'h0, 1'b1, WRITE_ENABLE_CODE, 2'h0};
    rows[1] = '{READ_CODE, 4'h0, 1'b1, READ_CODE, 2'h0};
    rows[2] = '{PD_CODE, 4'h0, 1'b1, PD_CODE, 2'h3};
    rows[3] = '{WRITE_ENABLE_CODE, 4'h0, 1'b0, PD_CODE, 2'h3};
    rows[4] = '{WAKE_CODE, 4'h2, 1'b0, PD_CODE, 2'h3};
    rows[5] = '{WAKE_CODE, 4'h0, 1'b0, PD_CODE, 2'h0};
    rows[6] = '{READ_CODE, 4'h0, 1'b1, READ_CODE, 2'h0};
    repeat (10) @(posedge i_clock);
    #1;
    check("state at reset", {6'h00, o_power_state}, 8'h00);
    check("valid at reset", {7'h00, o_cmd_valid}, 8'h00);
    i_rst_b = 1'b1;
    tick(2);
    check("status at power-up", o_status, STATUS_RESET);
    check("array fill", o_array_fill, ERASED_BYTE);
    check("inhibit at power-up", {7'h00, o_write_inhibit}, 8'h01);
    check("write barred at power-up", {7'h00, o_write_allowed}, 8'h00);
    send(WRITE_ENABLE_CODE, 4'h0);
    check("early write refused", {7'h00, seen_valid}, 8'h00);
    send(READ_CODE, 4'h0);
    check("early read served", {7'h00, seen_valid}, 8'h01);
    check("early read code", seen_code, READ_CODE);
    while (o_write_allowed !== 1'b1) tick(1);
    check("inhibit over", {7'h00, o_write_inhibit}, 8'h00);
    foreach (rows[k]) begin
      send(rows[k].instr, rows[k].extra);
      check("row valid", {7'h00, seen_valid}, {7'h00, rows[k].exp_valid});
      if (rows[k].exp_valid === 1'b1) check("row code", seen_code, rows[k].exp_code);
      check("row state", {6'h00, o_power_state}, {6'h00, rows[k].exp_state});
    end
    // the write enable of the first row must have set the latch
    check("latch after rows", o_status, 8'h02);
    // a wake that lands on a running cycle must be dropped, cycle untouched
    send(PD_CODE, 4'h0);
    i_cycle_start = 1'b1;
    tick(1);
    i_cycle_start = 1'b0;
    tick(2);
    check("busy set latch cleared", o_status, 8'h01);
    send(WAKE_CODE, 4'h0);
    check("wake while busy", {6'h00, o_power_state}, 8'h03);
    check("busy kept", o_status, 8'h01);
    i_cycle_done = 1'b1;
    tick(1);
    i_cycle_done = 1'b0;
    tick(2);
    check("busy cleared", o_status, 8'h00);
    send(WAKE_CODE, 4'h0);
    check("wake after cycle", {6'h00, o_power_state}, 8'h00);
    send(PD_CODE, 4'h0);
    i_rst_b = 1'b0;
    tick(2);
    check("state in second reset", {6'h00, o_power_state}, 8'h00);
    check("status in second reset", o_status, STATUS_RESET);
    check("valid in second reset", {7'h00, o_cmd_valid}, 8'h00);
    i_rst_b = 1'b1;
    send(READ_CODE, 4'h0);
    check("read after reset", {7'h00, seen_valid}, 8'h01);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    close_out();
  end
endmodule
